// >>> hw/afe_coder.sv
`timescale 1ns/1ps
// Turns a signed filter result into the output code for one converter
module afe_coder #(
    parameter int W = 24
) (
    input  wire logic [W-1:0] raw,
    input  wire logic         unipolar,
    input  wire logic         no_ref,
    output logic      [W-1:0] code
);
    always_comb
    begin
        if (no_ref)
        begin
            code = {W{1'b1}};
        end
        else if (unipolar)
        begin
            // Negative excursions clamp to zero in straight binary
            code = raw[W-1] ? '0 : {raw[W-2:0], 1'b0};
            // Doubling leaves the LSB clear, so only the top positive value saturates
            if (!raw[W-1] && (&raw[W-2:0]))
            begin
                code = {W{1'b1}};
            end
        end
        else
        begin
            code = {~raw[W-1], raw[W-2:0]};
        end
    end
endmodule

// >>> hw/afe_control.sv
`timescale 1ns/1ps
module afe_control (
    input  wire logic                                mclk,
    input  wire logic                                reset,
    // Register contents written by software, plus the status read strobe
    input  wire logic [7:0]                          primary_conv_control,
    input  wire logic [7:0]                          aux_conv_control,
    input  wire logic [7:0]                          current_source_control,
    input  wire logic                                status_read,
    // Converter sequencing from the modulator side
    input  wire logic                                pri_start,
    input  wire logic                                aux_start,
    input  wire logic                                pri_cal,
    input  wire logic                                aux_cal,
    input  wire logic                                pri_result_valid,
    input  wire logic [afe_pkg::PRIMARY_WIDTH-1:0]   pri_raw,
    input  wire logic                                aux_result_valid,
    input  wire logic [afe_pkg::AUX_WIDTH-1:0]       aux_raw,
    // Reference detector comparators (asynchronous)
    input  wire logic                                ref_below_min,
    input  wire logic                                reference_pin_pos_open,
    input  wire logic                                reference_pin_neg_open,
    // Analog controls
    output logic [afe_pkg::RANGE_WIDTH-1:0]          pri_gain_range,
    output logic                                     pri_ref_external,
    output logic                                     aux_ref_external,
    output logic                                     burnout_source_on,
    output logic                                     burnout_sink_on,
    output logic [1:0]                               excitation_out_a,
    output logic [1:0]                               excitation_out_b,
    // Results
    output logic [afe_pkg::PRIMARY_WIDTH-1:0]        pri_data,
    output logic [afe_pkg::AUX_WIDTH-1:0]            aux_data,
    output logic                                     pri_cal_write,
    output logic                                     aux_cal_write,
    output logic [7:0]                               conv_status_register,
    output logic                                     no_reference_flag,
    output logic                                     primary_cal_error,
    output logic                                     aux_cal_error,
    output logic [1:0]                               conversion_done_flags
);
    logic [2:0] ref_sync1;
    logic [2:0] ref_sync2;
    logic       pri_busy_cal;
    logic       aux_busy_cal;
    logic       pri_cal_bad;
    logic       aux_cal_bad;
    logic       pri_unipolar;
    logic       aux_unipolar;
    logic [afe_pkg::PRIMARY_WIDTH-1:0] pri_code;
    logic [afe_pkg::AUX_WIDTH-1:0]     aux_code;

    // Detector outputs are analog and asynchronous to mclk
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            ref_sync1 <= 3'h0;
            ref_sync2 <= 3'h0;
        end
        else
        begin
            ref_sync1 <= {ref_below_min, reference_pin_pos_open, reference_pin_neg_open};
            ref_sync2 <= ref_sync1;
        end
    end

    // Flag follows the detector, so it clears once a valid reference returns
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            no_reference_flag <= 1'b0;
        end
        else
        begin
            no_reference_flag <= |ref_sync2;
        end
    end

    // Settings latched at conversion start so mid-conversion writes wait
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            pri_gain_range   <= afe_pkg::PRI_CONTROL_RESET[afe_pkg::PRI_RANGE_LSB +: 3];
            pri_unipolar     <= 1'b0;
            pri_ref_external <= 1'b0;
        end
        else if (pri_start || pri_cal)
        begin
            pri_gain_range   <= primary_conv_control[afe_pkg::PRI_RANGE_LSB +: 3];
            pri_unipolar     <= primary_conv_control[afe_pkg::PRI_UNIPOLAR];
            pri_ref_external <= primary_conv_control[afe_pkg::PRI_EXT_REF];
        end
    end

    // Auxiliary has no range field: span fixed by the reference, unipolar or bipolar by AUX_UNIPOLAR
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            aux_unipolar     <= 1'b0;
            aux_ref_external <= 1'b0;
        end
        else if (aux_start || aux_cal)
        begin
            aux_unipolar     <= aux_conv_control[afe_pkg::AUX_UNIPOLAR];
            aux_ref_external <= aux_conv_control[afe_pkg::AUX_EXT_REF];
        end
    end

    // Current sources follow the register directly
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            burnout_source_on <= 1'b0;
            burnout_sink_on   <= 1'b0;
            excitation_out_a  <= 2'h0;
            excitation_out_b  <= 2'h0;
        end
        else
        begin
            burnout_source_on <= current_source_control[afe_pkg::BURNOUT_EN];
            burnout_sink_on   <= current_source_control[afe_pkg::BURNOUT_EN];
            if (current_source_control[afe_pkg::EXC_COMBINE])
            begin
                // Both sources steered to the one chosen pin, count 2 = 400 uA
                excitation_out_a <= current_source_control[afe_pkg::EXC_COMBINE_PIN]
                                    ? 2'h0 : 2'h2;
                excitation_out_b <= current_source_control[afe_pkg::EXC_COMBINE_PIN]
                                    ? 2'h2 : 2'h0;
            end
            else
            begin
                excitation_out_a <= {1'b0, current_source_control[afe_pkg::EXC_A_EN]};
                excitation_out_b <= {1'b0, current_source_control[afe_pkg::EXC_B_EN]};
            end
        end
    end

    afe_coder #(.W(afe_pkg::PRIMARY_WIDTH)) u_pri_coder (
        .raw      (pri_raw),
        .unipolar (pri_unipolar),
        .no_ref   (no_reference_flag),
        .code     (pri_code)
    );

    afe_coder #(.W(afe_pkg::AUX_WIDTH)) u_aux_coder (
        .raw      (aux_raw),
        .unipolar (aux_unipolar),
        .no_ref   (no_reference_flag),
        .code     (aux_code)
    );

    // Calibration tracking: any missing-reference cycle spoils the run
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            pri_busy_cal <= 1'b0;
            pri_cal_bad  <= 1'b0;
            aux_busy_cal <= 1'b0;
            aux_cal_bad  <= 1'b0;
        end
        else
        begin
            if (pri_cal)
            begin
                pri_busy_cal <= 1'b1;
                pri_cal_bad  <= no_reference_flag;
            end
            else if (pri_result_valid)
            begin
                pri_busy_cal <= 1'b0;
            end
            else if (pri_busy_cal && no_reference_flag)
            begin
                pri_cal_bad <= 1'b1;
            end
            if (aux_cal)
            begin
                aux_busy_cal <= 1'b1;
                aux_cal_bad  <= no_reference_flag;
            end
            else if (aux_result_valid)
            begin
                aux_busy_cal <= 1'b0;
            end
            else if (aux_busy_cal && no_reference_flag)
            begin
                aux_cal_bad <= 1'b1;
            end
        end
    end

    // Results, calibration writes, ready and error flags
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            pri_data              <= '0;
            aux_data              <= '0;
            pri_cal_write         <= 1'b0;
            aux_cal_write         <= 1'b0;
            primary_cal_error     <= 1'b0;
            aux_cal_error         <= 1'b0;
            conversion_done_flags <= 2'h0;
        end
        else
        begin
            pri_cal_write <= 1'b0;
            aux_cal_write <= 1'b0;
            // Reading the status clears ready and error; a new event wins
            if (status_read)
            begin
                conversion_done_flags <= 2'h0;
                primary_cal_error     <= 1'b0;
                aux_cal_error         <= 1'b0;
            end
            if (pri_result_valid)
            begin
                conversion_done_flags[1] <= 1'b1;
                if (!pri_busy_cal)
                begin
                    pri_data <= pri_code;
                end
                else if (pri_cal_bad || no_reference_flag)
                begin
                    primary_cal_error <= 1'b1;
                end
                else
                begin
                    pri_cal_write <= 1'b1;
                end
            end
            if (aux_result_valid)
            begin
                conversion_done_flags[0] <= 1'b1;
                if (!aux_busy_cal)
                begin
                    aux_data <= aux_code;
                end
                else if (aux_cal_bad || no_reference_flag)
                begin
                    aux_cal_error <= 1'b1;
                end
                else
                begin
                    aux_cal_write <= 1'b1;
                end
            end
        end
    end

    always_comb
    begin
        conv_status_register = 8'h00;
        conv_status_register[afe_pkg::STAT_PRI_DONE] = conversion_done_flags[1];
        conv_status_register[afe_pkg::STAT_AUX_DONE] = conversion_done_flags[0];
        conv_status_register[afe_pkg::STAT_NO_REF]   = no_reference_flag;
        conv_status_register[afe_pkg::STAT_PRI_ERR]  = primary_cal_error;
        conv_status_register[afe_pkg::STAT_AUX_ERR]  = aux_cal_error;
    end
endmodule

// >>> hw/afe_pkg.sv
package afe_pkg;
    // Conversion widths
    localparam int PRIMARY_WIDTH = 24;
    localparam int AUX_WIDTH     = 16;
    localparam int RANGE_WIDTH   = 3;

    // Primary control fields
    localparam int PRI_RANGE_LSB   = 0;
    localparam int PRI_UNIPOLAR    = 5;
    localparam int PRI_EXT_REF     = 6;
    localparam logic [7:0] PRI_CONTROL_RESET = 8'h07;

    // Auxiliary control fields
    localparam int AUX_UNIPOLAR    = 5;
    localparam int AUX_EXT_REF     = 6;
    localparam logic [7:0] AUX_CONTROL_RESET = 8'h00;

    // Current source control fields
    localparam int EXC_A_EN        = 0;
    localparam int EXC_B_EN        = 1;
    localparam int EXC_COMBINE     = 2;
    localparam int EXC_COMBINE_PIN = 3;
    localparam int BURNOUT_EN      = 6;
    localparam logic [7:0] CURRENT_CONTROL_RESET = 8'h00;

    // Status register layout
    localparam int STAT_PRI_DONE   = 7;
    localparam int STAT_AUX_DONE   = 6;
    localparam int STAT_NO_REF     = 4;
    localparam int STAT_PRI_ERR    = 3;
    localparam int STAT_AUX_ERR    = 2;

    // Nominal reference and range values in millivolts, source currents in nA and uA
    localparam int EXT_REF_MV      = 2500;
    localparam int INT_REF_MV      = 1250;
    localparam int MIN_REF_MV      = 300;
    localparam int BASE_RANGE_MV   = 20;
    localparam int BURNOUT_NA      = 100;
    localparam int EXC_UA          = 200;

    typedef enum logic [2:0] {
        AFE_IDLE = 3'b001,
        AFE_CONV = 3'b010,
        AFE_CAL  = 3'b100
    } afe_state_e;
endpackage

// >>> sim/afe_control_bench.sv
`timescale 1ns/1ps
module afe_control_bench;
    typedef struct {
        logic [7:0]  ctl;
        logic [23:0] raw;
        logic [23:0] exp;
        logic [15:0] araw;
        logic [15:0] aexp;
    } afe_row_s;
    logic        mclk = 1'b0;
    logic        reset = 1'b1;
    logic [7:0]  primary_conv_control = 8'h00, aux_conv_control = 8'h00;
    logic [7:0]  current_source_control = 8'h00, conv_status_register;
    logic        status_read = 1'b0, pri_start = 1'b0, aux_start = 1'b0;
    logic        pri_cal = 1'b0, aux_cal = 1'b0;
    logic        pri_result_valid = 1'b0, aux_result_valid = 1'b0;
    logic [23:0] pri_raw = 24'h00_0000, pri_data;
    logic [15:0] aux_raw = 16'h0000, aux_data;
    logic [15:0] ref_mv = 16'h09C4;
    logic [1:0]  pin_open = 2'b00, excitation_out_a, excitation_out_b, conversion_done_flags;
    logic [2:0]  pri_gain_range;
    logic        ref_below_min, reference_pin_pos_open, reference_pin_neg_open;
    logic        pri_ref_external, aux_ref_external, burnout_source_on, burnout_sink_on;
    logic        pri_cal_write, aux_cal_write, no_reference_flag;
    logic        primary_cal_error, aux_cal_error;
    int          miscompares = 0;
    int          total_checks = 0;
    int          cal_writes = 0;
    wire logic [5:0] sources = {burnout_source_on, burnout_sink_on, excitation_out_a,
        excitation_out_b};
    logic [7:0]  cur_in [5] = '{8'h40, 8'h03, 8'h07, 8'h0F, 8'h00};
    logic [5:0]  cur_exp [5] = '{6'h30, 6'h05, 6'h08, 6'h02, 6'h00};
    // Aux coding is always the opposite of the primary's, so the two bits stay separate
    afe_row_s    rows [8] = '{
        '{8'h60, 24'h00_0000, 24'h00_0000, 16'h0000, 16'h8000},
        '{8'h61, 24'h40_0000, 24'h80_0000, 16'h4000, 16'hC000},
        '{8'h22, 24'hF0_0000, 24'h00_0000, 16'h8000, 16'h0000},
        '{8'h43, 24'h00_0000, 24'h80_0000, 16'h0000, 16'h0000},
        '{8'h04, 24'h80_0000, 24'h00_0000, 16'h8000, 16'h0000},
        '{8'h45, 24'h7F_FFFF, 24'hFF_FFFF, 16'h4000, 16'h8000},
        '{8'h66, 24'h00_0001, 24'h00_0002, 16'h7FFF, 16'hFFFF},
        '{8'h07, 24'h12_3456, 24'h92_3456, 16'h0001, 16'h0002}};
    afe_control afe_control_inst (.*);
    afe_partner afe_partner_inst (.*);
    always #50 mclk = ~mclk;
    always @(posedge mclk) cal_writes <= cal_writes + pri_cal_write + aux_cal_write;
    task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
        total_checks++;
        if (got !== exp)
        begin
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
            miscompares++;
        end
    endtask
    task automatic convert(input logic cal, input logic [23:0] raw, input logic [15:0] araw);
        {pri_start, aux_start, pri_cal, aux_cal} = {~cal, ~cal, cal, cal};
        @(negedge mclk);
        {pri_start, aux_start, pri_cal, aux_cal} = 4'h0;
        repeat (5) @(negedge mclk);
        {pri_result_valid, aux_result_valid, pri_raw, aux_raw} = {2'b11, raw, araw};
        @(negedge mclk);
        {pri_result_valid, aux_result_valid} = 2'b00;
        repeat (2) @(negedge mclk);
    endtask
    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        repeat (10) @(negedge mclk);
        reset = 1'b0;
        @(negedge mclk);
        chk("reset range", 3'h7, pri_gain_range);
        chk("reset status", 8'h00, conv_status_register);
        foreach (rows[i])
        begin
            primary_conv_control = rows[i].ctl;
            aux_conv_control = (rows[i].ctl & 8'h60) ^ 8'h20;
            convert(1'b0, rows[i].raw, rows[i].araw);
            chk("range", rows[i].ctl[2:0], pri_gain_range);
            chk("refs", {2{rows[i].ctl[6]}}, {pri_ref_external, aux_ref_external});
            chk("primary code", rows[i].exp, pri_data);
            chk("aux code", rows[i].aexp, aux_data);
            chk("ready", 2'b11, conversion_done_flags);
        end
        primary_conv_control = 8'h00;
        repeat (2) @(negedge mclk);
        chk("range held", 3'h7, pri_gain_range);
        foreach (cur_in[i])
        begin
            current_source_control = cur_in[i];
            repeat (2) @(negedge mclk);
            chk("sources", cur_exp[i], sources);
        end
        for (int i = 0; i < 3; i++)
        begin
            ref_mv = (i == 0) ? 16'h012B : 16'h09C4;
            pin_open = 2'(i);
            convert(1'b0, 24'h00_0000, 16'h0000);
            chk("status flag", 1'b1, conv_status_register[4]);
            chk("forced codes", 40'hFF_FFFF_FFFF, {pri_data, aux_data});
            ref_mv = 16'h09C4;
            pin_open = 2'b00;
            repeat (6) @(negedge mclk);
            chk("flag recovery", 1'b0, no_reference_flag);
        end
        cal_writes = 0;
        pin_open = 2'b01;
        convert(1'b1, 24'h00_0000, 16'h0000);
        chk("cal errors", 2'b11, {primary_cal_error, aux_cal_error});
        chk("blocked writes", 0, cal_writes);
        pin_open = 2'b00;
        status_read = 1'b1;
        @(negedge mclk);
        status_read = 1'b0;
        repeat (5) @(negedge mclk);
        chk("ready cleared", 2'b00, conversion_done_flags);
        convert(1'b1, 24'h00_0000, 16'h0000);
        chk("errors cleared", 2'b00, {primary_cal_error, aux_cal_error});
        chk("coefficient writes", 2, cal_writes);
        // Mid-run reset must drop sources and flags while registers still hold values
        current_source_control = 8'h40;
        repeat (2) @(negedge mclk);
        reset = 1'b1;
        @(negedge mclk);
        chk("reset sources", 6'h00, sources);
        chk("reset outputs", 8'h00, conv_status_register);
        repeat (9) @(negedge mclk);
        reset = 1'b0;
        repeat (2) @(negedge mclk);
        chk("restart sources", 6'h30, sources);
        chk("restart range", 3'h7, pri_gain_range);
        finish_test();
    end
    initial
    begin
        // About fifty times the expected run
        #1_000_000;
        miscompares++;
        finish_test();
    end
endmodule

// >>> sim/afe_control_chk.sv
`timescale 1ns/1ps
module afe_control_chk (
    input wire logic        mclk,
    input wire logic        reset,
    input wire logic [7:0]  primary_conv_control,
    input wire logic [7:0]  current_source_control,
    input wire logic        pri_start,
    input wire logic        pri_cal,
    input wire logic        pri_result_valid,
    input wire logic        ref_below_min,
    input wire logic        reference_pin_pos_open,
    input wire logic        reference_pin_neg_open,
    input wire logic [2:0]  pri_gain_range,
    input wire logic        pri_ref_external,
    input wire logic        burnout_source_on,
    input wire logic        burnout_sink_on,
    input wire logic [1:0]  excitation_out_a,
    input wire logic [1:0]  excitation_out_b,
    input wire logic [23:0] pri_data,
    input wire logic        pri_cal_write,
    input wire logic        no_reference_flag,
    input wire logic        primary_cal_error
);
    logic fault;
    logic in_cal;
    logic lost;
    assign fault = ref_below_min | reference_pin_pos_open | reference_pin_neg_open;
    // A flag seen anywhere from the cal pulse to its result spoils the coefficients
    always_ff @(posedge mclk or posedge reset)
        if (reset)
            {in_cal, lost} <= 2'b00;
        else
            {in_cal, lost} <= {pri_cal | (in_cal & ~pri_result_valid & ~pri_start),
                (pri_cal | in_cal) & (no_reference_flag | (lost & ~pri_cal))};
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    sequence s_fault; fault [*4]; endsequence
    sequence s_cal_bad; pri_result_valid && in_cal && (lost || no_reference_flag); endsequence
    sequence s_cal_good; pri_result_valid && in_cal && !lost && !no_reference_flag; endsequence
    sequence s_write_pulse; pri_cal_write ##1 !pri_cal_write; endsequence
    AST_NOREF_SET:
        assert property (s_fault |-> no_reference_flag) else $error("flag missing");
    AST_NOREF_CLEAR:
        assert property ((!fault) [*4] |-> !no_reference_flag) else $error("flag stuck");
    AST_NOREF_DATA:
        assert property (pri_result_valid && !in_cal && no_reference_flag
            |=> pri_data == 24'hFF_FFFF) else $error("result not forced");
    AST_CAL_BLOCK:
        assert property (s_cal_bad |=> !pri_cal_write && primary_cal_error)
            else $error("bad calibration taken");
    AST_CAL_OK:
        assert property (s_cal_good |=> s_write_pulse) else $error("calibration write lost");
    AST_RANGE:
        assert property (pri_start |=> pri_gain_range == $past(primary_conv_control[2:0])
            && pri_ref_external == $past(primary_conv_control[6])) else $error("settings lost");
    AST_BURNOUT:
        assert property (!$past(reset) |-> burnout_sink_on == burnout_source_on
            && burnout_source_on == $past(current_source_control[6])) else $error("burnout wrong");
    AST_EXC:
        assert property (!$past(reset) && !$past(current_source_control[2])
            |-> excitation_out_a == {1'b0, $past(current_source_control[0])}
            && excitation_out_b == {1'b0, $past(current_source_control[1])})
            else $error("excitation wrong");
endmodule

bind afe_control afe_control_chk afe_control_chk_inst (.*);

// >>> sim/afe_partner.sv
`timescale 1ns/1ps
// Reference source and its two pins as the detector comparators see them
module afe_partner (
    input  wire logic        mclk,
    input  wire logic [15:0] ref_mv,
    input  wire logic [1:0]  pin_open,
    output logic             ref_below_min,
    output logic             reference_pin_pos_open,
    output logic             reference_pin_neg_open
);
    // Comparators settle one edge late, never racing the bench's own writes
    always @(posedge mclk)
    begin
        ref_below_min <= ref_mv < 16'(afe_pkg::MIN_REF_MV);
        reference_pin_pos_open <= pin_open[0];
        reference_pin_neg_open <= pin_open[1];
    end
endmodule
